// ===== src/nv_pkg.sv
package nv_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam int ADDR_W        = 17;
	localparam int DATA_W        = 8;
	localparam int FIFO_DEPTH    = 16;
	// Opcode values (arbitrary defaults)
	localparam logic [7:0] OP_WRITE  = 8'h02;
	localparam logic [7:0] OP_READ   = 8'h03;
	localparam logic [7:0] OP_WREN   = 8'h06;
	localparam logic [7:0] OP_WRDIS  = 8'h04;
	localparam logic [7:0] OP_STWR   = 8'h01;
	localparam logic [7:0] OP_STORE  = 8'h3C;
	localparam logic [7:0] OP_RECALL = 8'h60;
	localparam logic [7:0] OP_ASOFF  = 8'h19;
	localparam logic [7:0] OP_ASON   = 8'h59;
	// Status byte fields taken by the status write command
	localparam int SR_BP0 = 2;
	localparam int SR_BP1 = 3;
	localparam int SR_PEN = 7;
	// Block protect boundaries
	localparam logic [16:0] QTR_BASE  = 17'h18000;
	localparam logic [16:0] HALF_BASE = 17'h10000;
	localparam logic [16:0] ADDR_LAST = 17'h1FFFF;
	// Synchronised pin positions
	localparam int P_SCK  = 0;
	localparam int P_CS   = 1;
	localparam int P_SI   = 2;
	localparam int P_HOLD = 3;
	localparam int P_WP   = 4;
	localparam int P_HSB  = 5;
	localparam int P_SUP  = 6;
	localparam logic [6:0] PIN_IDLE  = 7'h3A;
	localparam logic [2:0] PREV_IDLE = 3'h2;
	// Short times in ns and their cycle counts (least times, rounded up)
	localparam int HW_DELAY_NS  = 100;
	localparam int HHHD_NS      = 20;
	localparam int LZHSB_NS     = 40;
	localparam int CLEAR_NS     = 64;
	localparam int HW_DELAY_CYC = (HW_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HHHD_CYC     = (HHHD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LZHSB_CYC    = (LZHSB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLEAR_CYC    = (CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [5:0] {
		SP_OPC  = 6'h01,
		SP_ADR  = 6'h02,
		SP_WR   = 6'h04,
		SP_RD   = 6'h08,
		SP_STAT = 6'h10,
		SP_IGN  = 6'h20
	} spi_state_t;
	typedef enum logic [7:0] {
		NV_IDLE  = 8'h01,
		NV_HWDLY = 8'h02,
		NV_ERASE = 8'h04,
		NV_PROG  = 8'h08,
		NV_HIGH  = 8'h10,
		NV_POST  = 8'h20,
		NV_RCLR  = 8'h40,
		NV_RCOPY = 8'h80
	} nv_state_t;
endpackage

// ===== src/nv_mem.sv
module nv_mem
	import nv_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              clk_en,
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	output logic      [DATA_W-1:0] rdata
);
	logic [DATA_W-1:0] ram [0:(2**ADDR_W)-1];

	always_ff @(posedge clock) begin
		if (clk_en) begin
			if (we) begin
				ram[addr] <= wdata;
			end
			rdata <= ram[addr];
		end
	end
endmodule

// ===== src/nv_fifo.sv
module nv_fifo
	import nv_pkg::*;
#(
	parameter int W = 25,
	parameter int D = 16
) (
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic         clk_en,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int PW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] buf_q;
		logic [PW-1:0]       wp;
		logic [PW-1:0]       rp;
		logic [PW:0]         cnt;
	} fifo_st_t;
	fifo_st_t r_reg, r_next;
	logic push, pop;

	assign in_ready  = r_reg.cnt != (PW+1)'(D);
	assign out_valid = r_reg.cnt != '0;
	assign out_data  = r_reg.buf_q[r_reg.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		r_next = r_reg;
		if (push) begin
			r_next.buf_q[r_reg.wp] = in_data;
			r_next.wp = PW'(r_reg.wp + 1'b1);
		end
		if (pop) begin
			r_next.rp = PW'(r_reg.rp + 1'b1);
		end
		r_next.cnt = (PW+1)'(r_reg.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r_reg <= '0;
		end else if (clk_en) begin
			r_reg <= r_next;
		end
	end
endmodule

// ===== src/nv_sram_save_restore_access.sv
module nv_sram_save_restore_access
	import nv_pkg::*;
#(
	parameter int STORE_NS   = 8000000,
	parameter int RECALL_NS  = 200000,
	parameter int POWERUP_NS = 20000000
) (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	input  wire logic spi_sck,
	input  wire logic spi_cs_n,
	input  wire logic spi_si,
	output logic      spi_so,
	output logic      spi_so_oe,
	input  wire logic hold_n,
	input  wire logic write_protect_n,
	input  wire logic supply_ok,
	input  wire logic store_busy_line_in,
	output logic      store_busy_line_out,
	output logic      store_busy_line_oe,
	output logic      busy_flag,
	output logic      access_blocked,
	output logic      block_protect_low,
	output logic      block_protect_high,
	output logic      protect_pin_enable,
	output logic      auto_save_en,
	output logic      write_overrun,
	output logic      nv_erase,
	output logic      nv_program,
	output logic      sram_clear,
	output logic      nv_copy
);
	localparam int STORE_CYC = (STORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_CYC = STORE_CYC / 2;
	localparam int PROG_CYC  = STORE_CYC - ERASE_CYC;
	localparam int RCL_CYC   = (RECALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - CLEAR_CYC;
	localparam int PWR_CYC   = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - CLEAR_CYC;

	typedef struct packed {
		logic [6:0]  s1;
		logic [6:0]  s2;
		logic [2:0]  prev;
		spi_state_t  spi;
		logic [4:0]  bits;
		logic [23:0] sh;
		logic        wr;
		logic [16:0] addr;
		logic [7:0]  tx;
		logic        so;
		logic        rd_load;
		logic        wel;
		logic        pen;
		logic [1:0]  bp;
		logic        auto_en;
		logic        dirty;
		logic        ovr;
		logic        cmd_store;
		logic        cmd_recall;
		nv_state_t   nv;
		logic [31:0] cnt;
		logic        src_auto;
		logic        rcl_pwr;
	} st_t;
	st_t r, n;

	logic        rise, fall, cs_hi, hold_ok, inhibit, byte_done;
	logic        mem_re, push, set_dirty, clr_dirty, wr_ok, drop;
	logic        fifo_ready, fifo_valid;
	logic [24:0] fifo_out;
	logic [16:0] mem_addr;
	logic [7:0]  mem_rdata;
	logic [7:0]  nb;

	function automatic logic blocked(input logic [16:0] a, input logic [1:0] bp);
		case (bp)
			2'h1:    blocked = a >= QTR_BASE;
			2'h2:    blocked = a >= HALF_BASE;
			2'h3:    blocked = 1'b1;
			default: blocked = 1'b0;
		endcase
	endfunction

	assign rise      = r.s2[P_SCK] && !r.prev[0];
	assign fall      = !r.s2[P_SCK] && r.prev[0];
	assign cs_hi     = r.s2[P_CS];
	assign hold_ok   = r.s2[P_HOLD];
	assign inhibit   = (r.nv != NV_IDLE) || !r.s2[P_HSB] || !r.s2[P_SUP];
	assign byte_done = rise && hold_ok && !cs_hi && (r.bits[2:0] == 3'h7);
	assign nb        = {r.sh[6:0], r.s2[P_SI]};
	assign wr_ok     = r.wel && !(r.pen && !r.s2[P_WP]) && !blocked(r.addr, r.bp) && !inhibit;

	always_comb begin
		n            = r;
		mem_re       = 1'b0;
		push         = 1'b0;
		drop         = 1'b0;
		set_dirty    = 1'b0;
		clr_dirty    = 1'b0;
		n.s1         = {supply_ok, store_busy_line_in, write_protect_n, hold_n, spi_si, spi_cs_n, spi_sck};
		n.s2         = r.s1;
		n.prev       = {r.s2[P_SUP], r.s2[P_HSB], r.s2[P_SCK]};
		n.rd_load    = 1'b0;
		n.cmd_store  = 1'b0;
		n.cmd_recall = 1'b0;
		if (cs_hi) begin
			n.spi  = SP_OPC;
			n.bits = 5'h00;
		end else if (hold_ok && rise) begin
			n.sh   = {r.sh[22:0], r.s2[P_SI]};
			n.bits = 5'(r.bits + 5'h01);
			case (r.spi)
				SP_OPC: begin
					if (r.bits == 5'h07) begin
						n.bits = 5'h00;
						n.spi  = SP_IGN;
						if (!inhibit) begin
							case (nb)
								OP_WRITE: begin
									n.spi = SP_ADR;
									n.wr  = 1'b1;
								end
								OP_READ: begin
									n.spi = SP_ADR;
									n.wr  = 1'b0;
								end
								OP_WREN:   n.wel = 1'b1;
								OP_WRDIS:  n.wel = 1'b0;
								OP_STWR:   n.spi = SP_STAT;
								OP_STORE:  n.cmd_store = 1'b1;
								OP_RECALL: n.cmd_recall = 1'b1;
								OP_ASOFF:  n.auto_en = 1'b0;
								OP_ASON:   n.auto_en = 1'b1;
								default:   n.spi = SP_IGN;
							endcase
						end
					end
				end
				SP_ADR: begin
					if (r.bits == 5'h17) begin
						n.bits = 5'h00;
						n.addr = n.sh[16:0];
						if (r.wr) begin
							n.spi = SP_WR;
						end else begin
							n.spi     = SP_RD;
							mem_re    = 1'b1;
							n.rd_load = 1'b1;
						end
					end
				end
				SP_WR: begin
					if (r.bits == 5'h07) begin
						n.bits = 5'h00;
						if (wr_ok) begin
							push      = fifo_ready;
							drop      = !fifo_ready;
							set_dirty = 1'b1;
						end
						n.addr = 17'(r.addr + 17'h00001);
					end
				end
				SP_RD: begin
					if (r.bits == 5'h07) begin
						n.bits    = 5'h00;
						n.addr    = 17'(r.addr + 17'h00001);
						mem_re    = 1'b1;
						n.rd_load = 1'b1;
					end
				end
				SP_STAT: begin
					if (r.bits == 5'h07) begin
						n.spi = SP_IGN;
						if (r.wel) begin
							n.bp  = {nb[SR_BP1], nb[SR_BP0]};
							n.pen = nb[SR_PEN];
						end
					end
				end
				SP_IGN: n.spi = SP_IGN;
				default: n.spi = SP_IGN;
			endcase
		end
		if (inhibit && (r.spi == SP_ADR || r.spi == SP_WR || r.spi == SP_RD)) begin
			n.spi     = SP_IGN;
			mem_re    = 1'b0;
			n.rd_load = 1'b0;
		end
		if (!cs_hi && hold_ok && fall && r.spi == SP_RD) begin
			n.so = r.tx[7];
			n.tx = {r.tx[6:0], 1'b0};
		end
		if (r.rd_load) begin
			n.tx = mem_rdata;
		end
		n.ovr = (r.ovr && !cs_hi) || drop;

		case (r.nv)
			NV_IDLE: begin
				if (r.s2[P_SUP] && !r.prev[2]) begin
					n.nv      = NV_RCLR;
					n.cnt     = 32'(CLEAR_CYC - 1);
					n.rcl_pwr = 1'b1;
					clr_dirty = 1'b1;
				end else if (!r.s2[P_SUP] && r.prev[2]) begin
					if (r.auto_en && r.dirty) begin
						n.nv       = NV_ERASE;
						n.cnt      = 32'(ERASE_CYC - 1);
						n.src_auto = 1'b1;
						clr_dirty  = 1'b1;
					end
				end else if (r.cmd_store) begin
					n.nv       = NV_ERASE;
					n.cnt      = 32'(ERASE_CYC - 1);
					n.src_auto = 1'b0;
					clr_dirty  = 1'b1;
				end else if (r.cmd_recall) begin
					n.nv      = NV_RCLR;
					n.cnt     = 32'(CLEAR_CYC - 1);
					n.rcl_pwr = 1'b0;
					clr_dirty = 1'b1;
				end else if (!r.s2[P_HSB] && r.prev[1]) begin
					n.nv  = NV_HWDLY;
					n.cnt = 32'(HW_DELAY_CYC - 1);
				end
			end
			NV_HWDLY: begin
				if (r.cnt == 32'h0) begin
					if (r.dirty) begin
						n.nv       = NV_ERASE;
						n.cnt      = 32'(ERASE_CYC - 1);
						n.src_auto = 1'b0;
						clr_dirty  = 1'b1;
					end else begin
						n.nv = NV_IDLE;
					end
				end else begin
					n.cnt = 32'(r.cnt - 32'h1);
				end
			end
			NV_ERASE: begin
				if (r.cnt == 32'h0) begin
					n.nv  = NV_PROG;
					n.cnt = 32'(PROG_CYC - 1);
				end else begin
					n.cnt = 32'(r.cnt - 32'h1);
				end
			end
			NV_PROG: begin
				if (r.cnt == 32'h0) begin
					n.nv  = r.src_auto ? NV_IDLE : NV_HIGH;
					n.cnt = 32'(HHHD_CYC - 1);
				end else begin
					n.cnt = 32'(r.cnt - 32'h1);
				end
			end
			NV_HIGH: begin
				if (r.cnt == 32'h0) begin
					n.nv  = NV_POST;
					n.cnt = 32'(LZHSB_CYC - 1);
				end else begin
					n.cnt = 32'(r.cnt - 32'h1);
				end
			end
			NV_POST: begin
				if (r.cnt == 32'h0) begin
					n.nv = NV_IDLE;
				end else begin
					n.cnt = 32'(r.cnt - 32'h1);
				end
			end
			NV_RCLR: begin
				if (r.cnt == 32'h0) begin
					n.nv  = NV_RCOPY;
					n.cnt = r.rcl_pwr ? 32'(PWR_CYC - 1) : 32'(RCL_CYC - 1);
				end else begin
					n.cnt = 32'(r.cnt - 32'h1);
				end
			end
			NV_RCOPY: begin
				if (r.cnt == 32'h0) begin
					n.nv = NV_IDLE;
				end else begin
					n.cnt = 32'(r.cnt - 32'h1);
				end
			end
			default: n.nv = NV_IDLE;
		endcase
		n.dirty = (r.dirty && !clr_dirty) || set_dirty;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r         <= '0;
			r.s1      <= PIN_IDLE;
			r.s2      <= PIN_IDLE;
			r.prev    <= PREV_IDLE;
			r.spi     <= SP_OPC;
			r.nv      <= NV_IDLE;
			r.auto_en <= 1'b1;
		end else if (clk_en) begin
			r <= n;
		end
	end

	assign mem_addr = mem_re ? n.addr : fifo_out[24:8];

	nv_fifo #(.W(25), .D(FIFO_DEPTH)) u_fifo (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.in_data   ({r.addr, nb}),
		.out_valid (fifo_valid),
		.out_ready (!mem_re),
		.out_data  (fifo_out)
	);

	nv_mem u_mem (
		.clock  (clock),
		.clk_en (clk_en),
		.we     (fifo_valid && !mem_re),
		.addr   (mem_addr),
		.wdata  (fifo_out[7:0]),
		.rdata  (mem_rdata)
	);

	assign spi_so              = r.so;
	assign spi_so_oe           = !cs_hi && hold_ok && r.spi == SP_RD;
	assign store_busy_line_out = r.nv == NV_HIGH;
	// Software restore also pulls the line low; power-up restore leaves it to the pull-up
	assign store_busy_line_oe  = r.nv == NV_ERASE || r.nv == NV_PROG || r.nv == NV_HIGH
	                             || (!r.rcl_pwr && (r.nv == NV_RCLR || r.nv == NV_RCOPY));
	assign busy_flag           = r.nv == NV_ERASE || r.nv == NV_PROG || r.nv == NV_RCLR || r.nv == NV_RCOPY;
	assign access_blocked      = inhibit;
	assign block_protect_low   = r.bp[0];
	assign block_protect_high  = r.bp[1];
	assign protect_pin_enable  = r.pen;
	assign auto_save_en        = r.auto_en;
	assign write_overrun       = r.ovr;
	assign nv_erase            = r.nv == NV_ERASE;
	assign nv_program          = r.nv == NV_PROG;
	assign sram_clear          = r.nv == NV_RCLR;
	assign nv_copy             = r.nv == NV_RCOPY;

	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence s_prog_end;
		r.nv == NV_PROG && r.cnt == 32'h0 && !r.src_auto && clk_en;
	endsequence
	property p_high_after;
		s_prog_end |=> store_busy_line_oe && store_busy_line_out ##1 store_busy_line_oe;
	endproperty

	chk_busy_pulls_low: assert property ((r.nv == NV_ERASE || r.nv == NV_PROG) |-> store_busy_line_oe && !store_busy_line_out)
		else $error("busy line not pulled low during save");
	chk_busy_flag_set: assert property (r.nv == NV_RCOPY |-> busy_flag && access_blocked)
		else $error("busy flag clear during restore");
	chk_erase_first: assert property (r.nv == NV_PROG |-> $past(r.nv) == NV_ERASE || $past(r.nv) == NV_PROG)
		else $error("program entered without erase");
	chk_restore_order: assert property (r.nv == NV_RCOPY |-> $past(r.nv) == NV_RCLR || $past(r.nv) == NV_RCOPY)
		else $error("copy entered without clear");
	chk_high_drive: assert property (p_high_after)
		else $error("busy line not driven high after save");
	chk_no_access_busy: assert property (r.nv != NV_IDLE |-> !push && !mem_re)
		else $error("array access while busy");
	chk_clean_skip: assert property (r.nv == NV_HWDLY && r.cnt == 32'h0 && !r.dirty && clk_en |=> r.nv == NV_IDLE)
		else $error("hardware save without prior write");
	chk_post_block: assert property (r.nv == NV_POST |-> access_blocked && !store_busy_line_oe)
		else $error("access open during post busy interval");
	chk_hold_stalls: assert property (!hold_ok && !cs_hi |-> n.bits == r.bits && n.spi == r.spi || inhibit)
		else $error("transfer advanced during hold");
	chk_addr_wraps: assert property (r.spi == SP_WR && r.addr == ADDR_LAST && byte_done |-> n.addr == 17'h00000)
		else $error("burst address did not wrap");
endmodule

// ===== testbench/nv_spi_master.sv
module nv_spi_master
	import nv_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       spi_so,
	output logic            spi_sck,
	output logic            spi_cs_n,
	output logic            spi_si,
	output logic            rx_done,
	output logic [7:0]      rx_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	logic listen, cpol;
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
		rx_done = 1'b0;
		rx_byte = 8'h00;
		listen = 1'b0;
		cpol = 1'b0;
	end
	// A 32 ns link clock: four system clocks per phase
	task automatic half();
		repeat (4) @(negedge clock);
	endtask
	task automatic go();
		spi_cs_n = 1'b0;
		half();
	endtask
	// Deselected SI shows the inverse of its last bit
	task automatic stop();
		half();
		spi_cs_n = 1'b1;
		spi_si = ~spi_si;
		half();
	endtask
	// Idle clock level picks mode 0 or 3; change only while deselected
	task automatic set_mode(input logic m);
		cpol = m;
		spi_sck = m;
		half();
	endtask
	// Mode 0 or 3, MSB first, SO taken at each rise
	task automatic xbyte(input logic [7:0] tx);
		for (int i = 7; i >= 0; i--) begin
			if (cpol) spi_sck = 1'b0;
			spi_si = tx[i];
			half();
			spi_sck = 1'b1;
			rx_byte = {rx_byte[6:0], spi_so};
			half();
			if (!cpol) spi_sck = 1'b0;
		end
		if (listen) begin
			rx_done = 1'b1;
			@(negedge clock);
			rx_done = 1'b0;
		end
	endtask
endmodule

// ===== testbench/nv_sram_save_restore_access_tb_top.sv
module nv_sram_save_restore_access_tb_top;
	import nv_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0, sys_rst = 1'b1, hold_n = 1'b1, write_protect_n = 1'b1, supply_ok = 1'b1, ext_low = 1'b0;
	logic spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe, hsb_out, hsb_oe, busy_flag, access_blocked;
	logic bpl, bph, pen, ase, wov, nv_erase, nv_program, sram_clear, nv_copy, rx_done, line_lvl, hd;
	logic [7:0] rx_byte;
	logic [7:0] mdl [logic [16:0]];
	logic [7:0] exp_q [$];
	logic [4:0] st_q = 5'h00;
	int fails = 0, cmp_count = 0, mon_bad = 0, erase_n = 0, clr_n = 0, hd_n = 0, oe_n = 0, blk = 0, low_n = 0;
	assign line_lvl = !((hsb_oe && !hsb_out) || ext_low);
	assign hd = hsb_oe && hsb_out;
	always #2 clock = ~clock;
	nv_sram_save_restore_access #(.STORE_NS(400), .RECALL_NS(400), .POWERUP_NS(400)) dut_u (
		.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
		.spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .hold_n(hold_n),
		.write_protect_n(write_protect_n), .supply_ok(supply_ok), .store_busy_line_in(line_lvl),
		.store_busy_line_out(hsb_out), .store_busy_line_oe(hsb_oe), .busy_flag(busy_flag),
		.access_blocked(access_blocked), .block_protect_low(bpl), .block_protect_high(bph),
		.protect_pin_enable(pen), .auto_save_en(ase), .write_overrun(wov), .nv_erase(nv_erase),
		.nv_program(nv_program), .sram_clear(sram_clear), .nv_copy(nv_copy));
	nv_spi_master mst_u (.clock(clock), .spi_so(spi_so), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
		.spi_si(spi_si), .rx_done(rx_done), .rx_byte(rx_byte));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (exp !== got) begin
			fails++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Scoreboard: oldest expected byte against each received byte
	always @(posedge clock) begin
		if (rx_done === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("unexpected byte", 32'h0, 32'h1);
			end else begin
				chk("read data", exp_q.pop_front(), rx_byte);
			end
		end
	end
	// Phase order, busy signalling and access blocking
	always @(negedge clock) begin
		if (^{nv_erase, nv_program, sram_clear, nv_copy, hd} === 1'bx) mon_bad++;
		if (nv_program && !st_q[3] && !st_q[4]) mon_bad++;
		if (nv_copy && !st_q[1] && !st_q[2]) mon_bad++;
		if ((nv_erase || nv_program) && !(hsb_oe && !hsb_out && busy_flag === 1'b1)) mon_bad++;
		if ((sram_clear || nv_copy) && busy_flag !== 1'b1) mon_bad++;
		if ((nv_erase || nv_program || sram_clear || nv_copy || blk > 0 || low_n > 4) && access_blocked !== 1'b1)
			mon_bad++;
		if (nv_erase && !st_q[4]) erase_n++;
		if (sram_clear && !st_q[2]) clr_n++;
		if (hd && !st_q[0]) begin
			hd_n++;
			blk = HHHD_CYC + LZHSB_CYC - 2;
		end else if (blk > 0) begin
			blk--;
		end
		low_n = line_lvl ? 0 : low_n + 1;
		if (spi_so_oe === 1'b1) oe_n++;
		st_q = {nv_erase, nv_program, sram_clear, nv_copy, hd};
	end
	task automatic idle_wait(input int e0);
		int k;
		k = 0;
		while (!(access_blocked === 1'b0 || (e0 >= 0 && erase_n > e0 && !nv_erase && !nv_program)) && k < 3000) begin
			@(negedge clock);
			k++;
		end
		if (k == 3000) begin
			fails++;
			$display("Error idle wait expected idle seen busy");
			tally_and_finish();
		end
	endtask
	task automatic cmd(input logic [7:0] op);
		mst_u.go();
		mst_u.xbyte(op);
		mst_u.stop();
	endtask
	task automatic sw(input logic [7:0] v);
		cmd(OP_WREN);
		mst_u.go();
		mst_u.xbyte(OP_STWR);
		mst_u.xbyte(v);
		mst_u.stop();
	endtask
	task automatic wr(input logic [16:0] a, input int n, input logic en, input logic upd, input int hold_at);
		logic [7:0] d;
		if (en) cmd(OP_WREN);
		mst_u.go();
		mst_u.xbyte(OP_WRITE);
		mst_u.xbyte({7'($urandom_range(127)), a[16]});
		mst_u.xbyte(a[15:8]);
		mst_u.xbyte(a[7:0]);
		for (int i = 0; i < n; i++) begin
			if (i == hold_at) begin
				hold_n = 1'b0;
				mst_u.xbyte(8'hA5);
				hold_n = 1'b1;
			end
			d = 8'($urandom);
			mst_u.xbyte(d);
			if (upd) mdl[17'(a + i)] = d;
		end
		mst_u.stop();
	endtask
	task automatic rd(input logic [16:0] a, input int n);
		mst_u.go();
		mst_u.xbyte(OP_READ);
		mst_u.xbyte({7'h00, a[16]});
		mst_u.xbyte(a[15:8]);
		mst_u.xbyte(a[7:0]);
		mst_u.listen = 1'b1;
		for (int i = 0; i < n; i++) begin
			exp_q.push_back(mdl[17'(a + i)]);
			mst_u.xbyte(8'($urandom));
		end
		mst_u.listen = 1'b0;
		mst_u.stop();
	endtask
	initial begin
		int e0, h0, o0;
		void'($urandom(32'hCC42E0C0));
		repeat (12) @(negedge clock);
		sys_rst = 1'b0;
		repeat (8) @(negedge clock);
		idle_wait(-1);
		chk("power-up clears", 1, clr_n);
		chk("auto save enable", 1, ase);
		$display("power-up restore done");
		wr(17'h1FFFE, 4, 1'b1, 1'b1, 2);
		wr(17'h00100, 2, 1'b1, 1'b1, 9);
		rd(17'h1FFFE, 4);
		rd(17'h00100, 2);
		$display("burst wrap done");
		mst_u.set_mode(1'b1);
		wr(17'h00200, 2, 1'b1, 1'b1, 9);
		rd(17'h00200, 2);
		mst_u.set_mode(1'b0);
		$display("mode 3 done");
		sw(8'h0C);
		chk("block protect", 3, {bph, bpl});
		wr(17'h00100, 1, 1'b1, 1'b0, 9);
		sw(8'h00);
		cmd(OP_WREN);
		cmd(OP_WRDIS);
		wr(17'h00100, 1, 1'b0, 1'b0, 9);
		sw(8'h80);
		chk("pin enable", 1, pen);
		write_protect_n = 1'b0;
		wr(17'h00100, 1, 1'b1, 1'b0, 9);
		write_protect_n = 1'b1;
		sw(8'h00);
		rd(17'h00100, 1);
		$display("write protection done");
		{e0, h0} = {erase_n, hd_n};
		repeat (8) @(negedge clock);
		ext_low = 1'b1;
		repeat (12) @(negedge clock);
		chk("held off", 1, access_blocked);
		ext_low = 1'b0;
		repeat (8) @(negedge clock);
		idle_wait(-1);
		chk("hardware save", e0 + 1, erase_n);
		chk("high drive", h0 + 1, hd_n);
		chk("line released", 0, hsb_oe);
		ext_low = 1'b1;
		repeat (12) @(negedge clock);
		ext_low = 1'b0;
		repeat (HW_DELAY_CYC + 20) @(negedge clock);
		idle_wait(-1);
		chk("clean request", e0 + 1, erase_n);
		$display("hardware save done");
		o0 = oe_n;
		cmd(OP_STORE);
		mst_u.go();
		for (int i = 0; i < 5; i++) mst_u.xbyte(i == 0 ? OP_READ : 8'h00);
		mst_u.stop();
		idle_wait(-1);
		chk("read refused", o0, oe_n);
		chk("command save", e0 + 2, erase_n);
		chk("command high drive", h0 + 2, hd_n);
		e0 = clr_n;
		cmd(OP_RECALL);
		repeat (8) @(negedge clock);
		chk("recall line low", 0, line_lvl);
		idle_wait(-1);
		chk("recall clears", e0 + 1, clr_n);
		$display("command save and recall done");
		wr(17'h00040, 1, 1'b1, 1'b1, 9);
		{e0, h0} = {erase_n, hd_n};
		supply_ok = 1'b0;
		repeat (10) @(negedge clock);
		chk("supply loss blocks", 1, access_blocked);
		idle_wait(e0);
		chk("auto save", e0 + 1, erase_n);
		chk("no high drive", h0, hd_n);
		supply_ok = 1'b1;
		repeat (8) @(negedge clock);
		idle_wait(-1);
		cmd(OP_ASOFF);
		chk("auto save off", 0, ase);
		wr(17'h00041, 1, 1'b1, 1'b1, 9);
		supply_ok = 1'b0;
		repeat (200) @(negedge clock);
		chk("auto save skipped", e0 + 1, erase_n);
		supply_ok = 1'b1;
		repeat (8) @(negedge clock);
		idle_wait(-1);
		cmd(OP_ASON);
		chk("auto save on", 1, ase);
		supply_ok = 1'b0;
		repeat (200) @(negedge clock);
		chk("clean auto skip", e0 + 1, erase_n);
		supply_ok = 1'b1;
		repeat (8) @(negedge clock);
		idle_wait(-1);
		sw(8'h00);
		chk("status rewrite", 0, {pen, bph, bpl});
		chk("write overrun", 0, wov);
		chk("monitor", 0, mon_bad);
		chk("scoreboard left", 0, exp_q.size());
		$display("power-down save done");
		tally_and_finish();
	end
endmodule
